// [src/wdtu_cycle_div.sv]
`timescale 1ns/1ps
module wdtu_cycle_div
  import wdtu_pkg::*;
(
  input wire logic clk_i, // Oscillator clock
  input wire logic rst_i, // Synchronous reset
  input wire logic run_i, // Divider may advance
  input wire logic single_speed_i, // High: 12 periods, low: 6
  output logic tick_o // One-cycle machine-cycle pulse
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } wdtu_div_s;

  wdtu_div_s q;
  wdtu_div_s next_q;
  logic [DIV_W-1:0] period_m1;

  always_comb begin
    next_q = q;
    period_m1 = single_speed_i ? DIV_W'(OSC_PER_CYCLE_SINGLE - 1) : DIV_W'(OSC_PER_CYCLE_DOUBLE - 1);
    next_q.tick = 1'b0;
    if (!run_i) begin
      // Restart phase so the first cycle after a stop is full length
      next_q.cnt = period_m1;
    end else if (q.cnt == '0 || q.cnt > period_m1) begin
      next_q.cnt = period_m1;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt - DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick_o = q.tick;

endmodule

// [src/wdtu_pkg.sv]
package wdtu_pkg;

  localparam int WDTU_ADDR_W = 8;
  localparam int WDTU_DATA_W = 8;

  // Register addresses
  localparam logic [7:0] WDOG_SERVICE_REG_ADDR = 8'ha6;
  localparam logic [7:0] WDOG_PERIOD_REG_ADDR = 8'ha7;
  localparam logic [7:0] WDOG_STATUS_REG_ADDR = 8'ha8;
  localparam logic [7:0] WDOG_BASE_LO_REG_ADDR = 8'ha9;
  localparam logic [7:0] WDOG_BASE_HI_REG_ADDR = 8'haa;
  localparam logic [7:0] WDOG_EXT_REG_ADDR = 8'hab;

  // Unlock keys
  localparam logic [7:0] WDOG_KEY_FIRST = 8'h1e;
  localparam logic [7:0] WDOG_KEY_SECOND = 8'he1;

  // Period register fields
  localparam int PERIOD_SEL_W = 3;
  localparam int PERIOD_SEL_LSB = 0;
  localparam logic [2:0] PERIOD_SEL_RESET = 3'h0;

  // Status register fields
  localparam int STATUS_ARMED_BIT = 0;
  localparam int STATUS_PULSE_BIT = 1;
  localparam int STATUS_HOLD_BIT = 2;
  localparam int STATUS_KEY_BIT = 3;

  // Counter chain widths
  localparam int BASE_W = 14;
  localparam int EXT_W = 7;

  // Timing counts in oscillator periods, and DIV_W, the width of the divider count
  localparam int RESET_PULSE_OSC = 96;
  localparam int OSC_PER_CYCLE_SINGLE = 12;
  localparam int OSC_PER_CYCLE_DOUBLE = 6;
  localparam int DIV_W = 4;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_KEY1
  } wdtu_seq_e;

endpackage

// [src/wdtu_sync2.sv]
`timescale 1ns/1ps
module wdtu_sync2
  import wdtu_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [W-1:0] async_i, // Raw pin level
  output logic [W-1:0] sync_o // Level after two flops
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } wdtu_sync_s;

  wdtu_sync_s q;
  wdtu_sync_s next_q;

  always_comb begin
    next_q = q;
    // First stage feeds only the second
    next_q.meta = async_i;
    next_q.stable = q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= {RESET_VAL, RESET_VAL};
    end else begin
      q <= next_q;
    end
  end

  assign sync_o = q.stable;

endmodule

// [src/wdtu_top.sv]
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module wdtu_top
  import wdtu_pkg::*;
(
  input wire logic CLK_SYS_I, // Oscillator clock
  input wire logic RESET_I, // Hardware reset, active high
  input wire logic [WDTU_ADDR_W-1:0] ADDR_I, // Register address
  input wire logic [WDTU_DATA_W-1:0] WDATA_I, // Write data
  input wire logic WR_I, // Write strobe
  input wire logic RD_I, // Read strobe
  output logic [WDTU_DATA_W-1:0] RDATA_O, // Read data, cycle after strobe
  input wire logic SINGLE_SPEED_CLOCK_MODE_I, // High: 12 osc per machine cycle
  input wire logic POWER_DOWN_I, // Oscillator stopped
  input wire logic WAKE_INT_N_I, // Level wake interrupt pin, low active
  output logic WDOG_RESET_O, // Reset pulse on overflow
  output logic WDOG_ARMED_O // Watchdog counting enabled
);

  localparam logic [6:0] PULSE_LAST = 7'(RESET_PULSE_OSC - 1);
  localparam logic [BASE_W-1:0] BASE_FULL = '1;

  typedef struct packed {
    logic armed;
    wdtu_seq_e seq;
    logic [PERIOD_SEL_W-1:0] sel;
    logic [BASE_W-1:0] base;
    logic [EXT_W-1:0] ext;
    logic pulse;
    logic [6:0] pulse_cnt;
    logic hold;
    logic pd_prev;
    logic [WDTU_DATA_W-1:0] rdata;
  } wdtu_state_s;

  wdtu_state_s q;
  wdtu_state_s next_q;

  logic wake_n_s;
  logic tick;
  logic div_run;
  logic cnt_en;
  logic ovf;
  logic svc_wr;
  logic key1_wr;
  logic key2_wr;
  logic prd_wr;
  logic bus_ok;

  // Stage mask: only the low select bits of the extension take part
  function automatic logic [EXT_W-1:0] sel_mask(input logic [PERIOD_SEL_W-1:0] sel);
    logic [EXT_W:0] m;
    m = ({{EXT_W{1'b0}}, 1'b1} << sel) - {{EXT_W{1'b0}}, 1'b1};
    return m[EXT_W-1:0];
  endfunction

  wdtu_sync2 #(
    .W(1),
    .RESET_VAL(1'b1)
  ) u_wake_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .async_i(WAKE_INT_N_I),
    .sync_o(wake_n_s)
  );

  // stopped oscillator means no machine cycles
  assign div_run = q.armed && !POWER_DOWN_I && !q.hold && !q.pulse;

  wdtu_cycle_div u_div (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .run_i(div_run),
    .single_speed_i(SINGLE_SPEED_CLOCK_MODE_I),
    .tick_o(tick)
  );

  // idle keeps the oscillator, no gating term for it
  assign cnt_en = tick && div_run;

  // limit is all ones across base and masked extension
  assign ovf = cnt_en && (q.base == BASE_FULL) && ((q.ext & sel_mask(q.sel)) == sel_mask(q.sel));

  // Writes ignored while the pulse holds the chip in reset; reads are still answered
  assign bus_ok = !q.pulse;
  assign svc_wr = bus_ok && WR_I && (ADDR_I == WDOG_SERVICE_REG_ADDR);
  assign key1_wr = svc_wr && (WDATA_I == WDOG_KEY_FIRST);
  assign key2_wr = svc_wr && (WDATA_I == WDOG_KEY_SECOND) && (q.seq == SEQ_KEY1);
  assign prd_wr = bus_ok && WR_I && (ADDR_I == WDOG_PERIOD_REG_ADDR);

  always_comb begin
    next_q = q;
    next_q.pd_prev = POWER_DOWN_I;

    if (bus_ok && (WR_I || RD_I)) begin
      next_q.seq = key1_wr ? SEQ_KEY1 : SEQ_IDLE;
    end

    if (prd_wr && !q.armed) begin
      // select field in the low bits
      next_q.sel = WDATA_I[PERIOD_SEL_LSB +: PERIOD_SEL_W];
    end

    // base counter carries into extension stage
    if (cnt_en) begin
      next_q.base = q.base + BASE_W'(1);
      if (q.base == BASE_FULL) begin
        next_q.ext = q.ext + EXT_W'(1);
      end
    end

    // second key arms and starts from zero
    if (key2_wr) begin
      next_q.armed = 1'b1;
      next_q.base = '0;
      next_q.ext = '0;
    end

    // hold after interrupt wake until line is high
    if (q.pd_prev && !POWER_DOWN_I && !wake_n_s) begin
      next_q.hold = 1'b1;
    end else if (wake_n_s) begin
      next_q.hold = 1'b0;
    end

    if (q.pulse) begin
      if (q.pulse_cnt == '0) begin
        next_q.pulse = 1'b0;
      end else begin
        next_q.pulse_cnt = q.pulse_cnt - 7'h01;
      end
    end

    // overflow is the only disarm besides hardware reset
    if (ovf) begin
      next_q.armed = 1'b0;
      next_q.seq = SEQ_IDLE;
      next_q.sel = PERIOD_SEL_RESET;
      next_q.base = '0;
      next_q.ext = '0;
      next_q.hold = 1'b0;
      next_q.pulse = 1'b1;
      next_q.pulse_cnt = PULSE_LAST;
    end

    next_q.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        WDOG_PERIOD_REG_ADDR: begin
          next_q.rdata[PERIOD_SEL_LSB +: PERIOD_SEL_W] = q.sel;
        end
        WDOG_STATUS_REG_ADDR: begin
          next_q.rdata[STATUS_ARMED_BIT] = q.armed;
          next_q.rdata[STATUS_PULSE_BIT] = q.pulse;
          next_q.rdata[STATUS_HOLD_BIT] = q.hold;
          next_q.rdata[STATUS_KEY_BIT] = (q.seq == SEQ_KEY1);
        end
        WDOG_BASE_LO_REG_ADDR: begin
          next_q.rdata = q.base[7:0];
        end
        WDOG_BASE_HI_REG_ADDR: begin
          next_q.rdata = {2'h0, q.base[BASE_W-1:8]};
        end
        WDOG_EXT_REG_ADDR: begin
          next_q.rdata = {1'h0, q.ext};
        end
        default: begin
          // Service register is write only; unmapped reads give zero
          next_q.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      // reset out of power-down also lands here
      q <= '{armed: 1'b0, seq: SEQ_IDLE, sel: PERIOD_SEL_RESET, base: '0, ext: '0,
             pulse: 1'b0, pulse_cnt: '0, hold: 1'b0, pd_prev: 1'b0, rdata: '0};
    end else begin
      q <= next_q;
    end
  end

  assign RDATA_O = q.rdata;
  assign WDOG_RESET_O = q.pulse;
  assign WDOG_ARMED_O = q.armed;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);

  reset_disarm_a: assert property ($fell(RESET_I) |-> !WDOG_ARMED_O && !WDOG_RESET_O)
    else $error("watchdog not disarmed after reset");

  arm_sequence_a: assert property (key2_wr && !ovf |=> WDOG_ARMED_O && q.base == '0 && q.ext == '0)
    else $error("key sequence did not arm or clear");

  no_single_key_a: assert property (!q.armed && !key2_wr |=> !q.armed)
    else $error("armed without full key sequence");

  count_step_a: assert property (cnt_en && !ovf && !key2_wr |=> q.base == $past(q.base) + BASE_W'(1))
    else $error("base count did not advance by one");

  stays_armed_a: assert property (q.armed && !ovf |=> q.armed)
    else $error("watchdog disarmed without overflow");

  pulse_width_a: assert property (ovf |=> WDOG_RESET_O ##95 WDOG_RESET_O ##1 !WDOG_RESET_O)
    else $error("reset pulse not 96 periods");

  period_lock_a: assert property (q.armed && !ovf |=> $stable(q.sel))
    else $error("period changed while armed");

  overflow_clear_a: assert property (ovf |=> !q.armed && q.base == '0 && q.ext == '0)
    else $error("overflow did not restart the chain");

  ext_carry_a: assert property (cnt_en && q.base == BASE_FULL && !ovf && !key2_wr
                                |=> q.ext == $past(q.ext) + EXT_W'(1) && q.base == '0)
    else $error("extension stage did not take the carry");

  pd_stop_a: assert property (POWER_DOWN_I && !key2_wr |=> $stable(q.base) && $stable(q.ext))
    else $error("counting during power-down");

  wake_hold_a: assert property (q.hold && !key2_wr |=> $stable(q.base))
    else $error("counting while wake line held low");

  hold_set_a: assert property (q.pd_prev && !POWER_DOWN_I && !wake_n_s && !ovf |=> q.hold)
    else $error("wake hold not taken");

  reset_clear_a: assert property ($fell(RESET_I) |-> q.base == '0 && q.ext == '0 && !q.hold)
    else $error("counts or hold survived reset");

  pulse_idle_a: assert property (q.pulse |-> !q.armed && q.seq == SEQ_IDLE)
    else $error("armed or key state during reset pulse");

  key_restart_a: assert property (bus_ok && (WR_I || RD_I) && !key1_wr |=> q.seq == SEQ_IDLE)
    else $error("key detection not restarted");

endmodule

// [verif/test_watchdog_timeout_unit.sv]
`timescale 1ns/1ps
module test_watchdog_timeout_unit;
  import wdtu_pkg::*;
  localparam logic [7:0] sv = WDOG_SERVICE_REG_ADDR;
  localparam logic [7:0] pr = WDOG_PERIOD_REG_ADDR;
  localparam logic [7:0] st = WDOG_STATUS_REG_ADDR;
  localparam logic [7:0] bl = WDOG_BASE_LO_REG_ADDR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic speed = 1'b1;
  logic pdown = 1'b0;
  logic wake_n = 1'b1;
  logic [7:0] rdata;
  logic wdog_rst;
  logic armed;
  logic [15:0] plen;
  logic pdone;
  logic rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [7:0] sel;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int cnt;

  always #4 clk = ~clk;

  wdtu_top i_dut (.CLK_SYS_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
    .RDATA_O(rdata), .SINGLE_SPEED_CLOCK_MODE_I(speed), .POWER_DOWN_I(pdown), .WAKE_INT_N_I(wake_n),
    .WDOG_RESET_O(wdog_rst), .WDOG_ARMED_O(armed));
  wdtu_reset_pin i_pin (.clk_i(clk), .pin_i(wdog_rst), .len_o(plen), .done_o(pdone));

  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    num_checks++;
    if (got !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic results;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    exp_q.push_back({8'h00, e & m});
    msk_q.push_back({8'h00, m});
    @(posedge clk);
    rd_s <= 1'b0;
  endtask

  task automatic key;
    wr(sv, WDOG_KEY_FIRST);
    wr(sv, WDOG_KEY_SECOND);
  endtask

  always @(posedge clk) begin
    rd_seen <= rd_s;
    cyc <= cyc + 1;
    if (cyc == 102000) begin
      err_total++;
      results();
    end
  end

  // Read data and pulse widths retire notes in order
  always @(negedge clk) begin
    if (rd_seen === 1'b1 || pdone === 1'b1) begin
      chk((rd_seen === 1'b1 ? {8'h00, rdata} : plen) & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(77000));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(st, 8'h00);
    rd(pr, 8'h00);
    repeat (40) @(posedge clk);
    rd(bl, 8'h00);
    sel = 8'($urandom % 8);
    wr(pr, sel);
    rd(pr, sel);
    rd(8'(8'h10 + $urandom % 128), 8'h00);
    rd(sv, 8'h00);
    wr(sv, WDOG_KEY_FIRST);
    rd(st, 8'h08);
    wr(sv, WDOG_KEY_SECOND);
    rd(st, 8'h00);
    key();
    rd(st, 8'h01);
    wr(pr, sel ^ 8'h07);
    rd(pr, sel);
    wr(sv, 8'h00);
    wr(st, 8'h00);
    rd(st, 8'h01);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(st, 8'h00);
    rd(pr, 8'h00);
    // Mid-tick sampling keeps a few cycles of slack
    key();
    repeat (126) @(posedge clk);
    pdown <= 1'b1;
    wake_n <= 1'b0;
    repeat (120) @(posedge clk);
    rd(bl, 8'd10);
    pdown <= 1'b0;
    repeat (120) @(posedge clk);
    rd(bl, 8'd10);
    rd(st, 8'h05);
    wake_n <= 1'b1;
    repeat (40) @(posedge clk);
    rd(st, 8'h01);
    key();
    speed <= 1'b0;
    rd(bl, 8'h00, 8'hfe);
    exp_q.push_back(16'd96);
    msk_q.push_back(16'hffff);
    cnt = 2;
    while (wdog_rst !== 1'b1 && cnt < 100000) begin
      @(negedge clk);
      cnt++;
    end
    chk(16'(cnt > 98284 && cnt < 98324), 16'h0001);
    cnt = 0;
    while (pdone !== 1'b1 && cnt < 200) begin
      @(negedge clk);
      cnt++;
    end
    chk({15'h0000, armed}, 16'h0000);
    rd(st, 8'h00);
    rd(pr, 8'h00);
    repeat (3) @(posedge clk);
    results();
  end
endmodule

// [verif/wdtu_reset_pin.sv]
`timescale 1ns/1ps
module wdtu_reset_pin (
  input wire logic clk_i, // System clock
  input wire logic pin_i, // Chip reset pin level
  output logic [15:0] len_o, // Width of the last pulse
  output logic done_o // One cycle after a pulse ends
);
  logic [15:0] cnt = 16'h0000;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (pin_i === 1'b1) begin
      cnt <= cnt + 16'h0001;
    end else if (cnt != 16'h0000) begin
      len_o <= cnt;
      done_o <= 1'b1;
      cnt <= 16'h0000;
    end
  end
endmodule
